// ===== verilog/hcm_params.svh
// Register map, field positions and reset values of the home coordinate manager
`ifndef HCM_PARAMS_SVH
`define HCM_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define HCM_OFS_CMD       8'h00
`define HCM_OFS_PRESET    8'h04
`define HCM_OFS_CONFIG    8'h08
`define HCM_OFS_STATUS    8'h0C
`define HCM_OFS_ELEC_HOME 8'h10
`define HCM_OFS_MECH_HOME 8'h14
`define HCM_OFS_REL_POS   8'h18
// ==========================================================
// Command register bits (write one to execute)
`define HCM_CMD_PRESET    0
`define HCM_CMD_CLEAR     1
`define HCM_CMD_FACTORY   2
// ==========================================================
// Config register fields
`define HCM_CFG_ABS_PERM  0
`define HCM_CFG_MECH_MAN  1
`define HCM_CFG_WRAP_MAN  2
`define HCM_CFG_LIMIT_DIS 3
`define HCM_CFG_PROT_DIS  4
`define HCM_CFG_MOTION_MAN 5
`define HCM_CFG_GEAR_LSB  16
`define HCM_CFG_GEAR_MSB  30
// ==========================================================
// Status register bits
`define HCM_ST_FACTORY    0
`define HCM_ST_USER       1
`define HCM_ST_ELEC       2
`define HCM_ST_VALID      3
`define HCM_ST_HOMING     4
`define HCM_ST_ABS_OK     5
`define HCM_ST_HS_OK      6
// ==========================================================
// Reset values
`define HCM_PRESET_RST    32'h00000000
`define HCM_CONFIG_RST    32'h00000000
`endif

// ===== verilog/hcm_pkg.sv
// Types shared by the home coordinate manager modules
`default_nettype none
package hcm_pkg;
   // Return-to-home tracking state
   typedef enum logic [0:0] {
      HCM_IDLE,
      HCM_HOMING
   } hcm_home_state_t;
endpackage : hcm_pkg
`default_nettype wire

// ===== verilog/hcm_sync.sv
// Two-flop synchroniser for pin levels
`default_nettype none
module hcm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   // ==========================================================
   // Synchroniser chain; first stage feeds only the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= '0;
         q_o      <= '0;
      end else begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule : hcm_sync
`default_nettype wire

// ===== verilog/hcm_wb_port.sv
// Classic Wishbone slave handshake and read/write enable generation
`default_nettype none
module hcm_wb_port (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_we_i,
   output logic            wb_ack_o,
   output logic            wr_en_o,
   output logic            rd_en_o
);
   wire req = wb_cyc_i & wb_stb_i;
   // ==========================================================
   // One wait state, ack drops the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
      end
   end
   // Writes take effect on the edge where the master samples ack; reads are latched one edge earlier, in the wait state
   assign wr_en_o = req & wb_we_i & wb_ack_o;
   assign rd_en_o = req & ~wb_we_i & ~wb_ack_o;
endmodule : hcm_wb_port
`default_nettype wire

// ===== verilog/hcm_home_coord.sv
// Home position and coordinate manager with Wishbone registers
`default_nettype none
`include "hcm_params.svh"
module hcm_home_coord
   import hcm_pkg::*;
#(
   parameter int PW = 32,
   parameter int GW = 15
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [31:0]   wb_dat_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic          wb_we_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic          factory_home_present_i,
   input  wire logic          electrical_preset_in_i,
   input  wire logic [PW-1:0] cmd_pos_i,
   input  wire logic          home_start_i,
   input  wire logic          home_done_i,
   input  wire logic          res_change_i,
   output logic               factory_origin_stored_o,
   output logic               user_origin_stored_o,
   output logic               electrical_preset_monitor_o,
   output logic               absolute_coord_valid_o,
   output logic               abs_move_ok_o,
   output logic               hs_home_ok_o,
   output logic               pos_load_o,
   output logic      [PW-1:0] pos_load_value_o,
   output logic      [PW-1:0] elec_home_o,
   output logic      [PW-1:0] mech_home_o,
   output logic      [PW-1:0] rel_pos_o,
   output logic               mech_src_manual_o,
   output logic      [GW-1:0] gear_ratio_o,
   output logic               gear_src_manual_o,
   output logic               wrap_src_manual_o,
   output logic               limit_disable_o,
   output logic               protect_disable_o,
   output logic               motion_param_source_o
);
   // ==========================================================
   // Byte-lane merge used for the preset and config words
   function automatic logic [31:0] hcm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : hcm_merge

   // ==========================================================
   // Bus handshake
   logic wr_en;
   logic rd_en;
   hcm_wb_port u_wb (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_we_i  (wb_we_i),
      .wb_ack_o (wb_ack_o),
      .wr_en_o  (wr_en),
      .rd_en_o  (rd_en)
   );

   // ==========================================================
   // Pin synchronisers
   logic [1:0] pin_sync;
   hcm_sync #(.W(2)) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({electrical_preset_in_i, factory_home_present_i}),
      .q_o   (pin_sync)
   );
   wire factory_sync = pin_sync[0];
   wire el_sync      = pin_sync[1];

   // ==========================================================
   // State registers
   logic            el_prev_reg;
   logic [31:0]     preset_reg;
   logic [31:0]     config_reg;
   logic            user_reg;
   logic            mech_set_reg;
   logic            preset_nz_reg;
   logic            elec_reg;
   logic            valid_reg;
   logic            factory_reg;
   logic [PW-1:0]   elec_home_reg;
   logic [PW-1:0]   mech_home_reg;
   logic [PW-1:0]   rel_reg;
   logic            load_reg;
   logic [PW-1:0]   load_val_reg;
   logic [31:0]     rdata_reg;
   hcm_home_state_t home_state_reg;
   hcm_home_state_t home_state_next;

   // ==========================================================
   // Address and command decode
   wire sel_cmd    = (wb_adr_i == `HCM_OFS_CMD);
   wire sel_preset = (wb_adr_i == `HCM_OFS_PRESET);
   wire sel_config = (wb_adr_i == `HCM_OFS_CONFIG);
   wire cmd_wr     = wr_en & sel_cmd & wb_sel_i[0];
   wire do_preset  = cmd_wr & wb_dat_i[`HCM_CMD_PRESET];
   wire do_clear   = cmd_wr & wb_dat_i[`HCM_CMD_CLEAR];
   wire do_factory = cmd_wr & wb_dat_i[`HCM_CMD_FACTORY];
   wire homing     = (home_state_reg == HCM_HOMING);
   wire home_fin   = homing & home_done_i;
   wire set_home   = do_preset | home_fin;
   wire el_rise    = el_sync & ~el_prev_reg;
   wire el_fall    = ~el_sync & el_prev_reg;
   wire res_lose   = res_change_i & preset_nz_reg;

   // ==========================================================
   // Coordinate validity and operation gating
   wire valid_next = (mech_set_reg | factory_reg | elec_reg) & ~homing;
   assign abs_move_ok_o = valid_reg | config_reg[`HCM_CFG_ABS_PERM];
   assign hs_home_ok_o  = valid_reg & ~elec_reg;
   wire [PW-1:0] home_base = elec_reg ? elec_home_reg : mech_home_reg;

   // ==========================================================
   // Return-to-home tracker
   always_comb begin
      home_state_next = home_state_reg;
      case (home_state_reg)
         HCM_IDLE:   if (home_start_i) home_state_next = HCM_HOMING;
         HCM_HOMING: if (home_done_i) home_state_next = HCM_IDLE;
         default:    home_state_next = HCM_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         home_state_reg <= HCM_IDLE;
      end else begin
         home_state_reg <= home_state_next;
      end
   end

   // ==========================================================
   // Software-written words
   always_ff @(posedge clk_i) begin
      if (rst_i || do_factory) begin
         preset_reg <= `HCM_PRESET_RST;
         config_reg <= `HCM_CONFIG_RST;
      end else if (wr_en && sel_preset) begin
         preset_reg <= hcm_merge(preset_reg, wb_dat_i, wb_sel_i);
      end else if (wr_en && sel_config) begin
         config_reg <= hcm_merge(config_reg, wb_dat_i, wb_sel_i);
      end
   end

   // ==========================================================
   // Factory home mirror, no write path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         factory_reg <= 1'b0;
      end else begin
         factory_reg <= factory_sync;
      end
   end

   // ==========================================================
   // User home and mechanical coordinate, set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         user_reg      <= 1'b0;
         mech_set_reg  <= 1'b0;
         preset_nz_reg <= 1'b0;
      end else if (set_home) begin
         user_reg      <= 1'b1;
         mech_set_reg  <= 1'b1;
         preset_nz_reg <= do_preset & (preset_reg != 32'h00000000);
      end else if (do_clear || do_factory) begin
         user_reg      <= 1'b0;
         mech_set_reg  <= 1'b0;
         preset_nz_reg <= 1'b0;
      end else if (res_lose || home_start_i) begin
         mech_set_reg  <= 1'b0;
      end
   end

   // ==========================================================
   // Mechanical home value and position load
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mech_home_reg <= '0;
         load_reg      <= 1'b0;
         load_val_reg  <= '0;
      end else begin
         load_reg <= set_home;
         if (set_home) begin
            mech_home_reg <= preset_reg[PW-1:0];
            load_val_reg  <= preset_reg[PW-1:0];
         end
      end
   end

   // ==========================================================
   // Electrical home capture and release
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         el_prev_reg   <= 1'b0;
         elec_reg      <= 1'b0;
         elec_home_reg <= '0;
      end else begin
         el_prev_reg <= el_sync;
         if (el_rise) begin
            elec_reg      <= 1'b1;
            elec_home_reg <= cmd_pos_i;
         end else if (el_fall) begin
            elec_reg <= 1'b0;
         end else if (set_home && elec_reg) begin
            elec_home_reg <= preset_reg[PW-1:0];
         end
      end
   end

   // ==========================================================
   // Registered status and relative coordinate
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_reg <= 1'b0;
         rel_reg   <= '0;
      end else begin
         valid_reg <= valid_next;
         rel_reg   <= cmd_pos_i - home_base;
      end
   end

   // ==========================================================
   // Read data, latched in the wait state; unmapped reads zero
   wire [31:0] status_word = {25'h0000000, hs_home_ok_o, abs_move_ok_o, homing,
                              valid_reg, elec_reg, user_reg, factory_reg};
   logic [31:0] rd_mux;
   always_comb begin
      case (wb_adr_i)
         `HCM_OFS_PRESET:    rd_mux = preset_reg;
         `HCM_OFS_CONFIG:    rd_mux = config_reg;
         `HCM_OFS_STATUS:    rd_mux = status_word;
         `HCM_OFS_ELEC_HOME: rd_mux = 32'(elec_home_reg);
         `HCM_OFS_MECH_HOME: rd_mux = 32'(mech_home_reg);
         `HCM_OFS_REL_POS:   rd_mux = 32'(rel_reg);
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h00000000;
      end else if (rd_en) begin
         rdata_reg <= rd_mux;
      end
   end

   // ==========================================================
   // Output wiring
   assign wb_dat_o                    = rdata_reg;
   assign factory_origin_stored_o     = factory_reg;
   assign user_origin_stored_o        = user_reg;
   assign electrical_preset_monitor_o = elec_reg;
   assign absolute_coord_valid_o      = valid_reg;
   assign pos_load_o                  = load_reg;
   assign pos_load_value_o            = load_val_reg;
   assign elec_home_o                 = elec_home_reg;
   assign mech_home_o                 = mech_home_reg;
   assign rel_pos_o                   = rel_reg;

   // ==========================================================
   // Parameter source selectors
   assign mech_src_manual_o     = config_reg[`HCM_CFG_MECH_MAN];
   assign gear_ratio_o          = config_reg[`HCM_CFG_GEAR_MSB:`HCM_CFG_GEAR_LSB];
   assign gear_src_manual_o     = (gear_ratio_o != '0);
   assign wrap_src_manual_o     = config_reg[`HCM_CFG_WRAP_MAN];
   assign limit_disable_o       = config_reg[`HCM_CFG_LIMIT_DIS];
   assign protect_disable_o     = config_reg[`HCM_CFG_PROT_DIS];
   assign motion_param_source_o = config_reg[`HCM_CFG_MOTION_MAN];

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   factory_mirror_a: assert property (
      1'b1 |=> factory_origin_stored_o == $past(factory_sync))
      else $error("factory flag did not follow encoder");
   user_set_a: assert property (
      set_home |=> user_origin_stored_o ##1 pos_load_o == 1'b0 || set_home)
      else $error("user home not stored");
   user_clear_a: assert property (
      (do_clear && !set_home) |=> !user_origin_stored_o && !mech_set_reg)
      else $error("user home not released");
   elec_capture_a: assert property (
      el_rise |=> electrical_preset_monitor_o && elec_home_o == $past(cmd_pos_i))
      else $error("electrical home not captured");
   elec_release_a: assert property (
      el_fall |=> !electrical_preset_monitor_o)
      else $error("electrical home not released");
   monitor_track_a: assert property (
      1'b1 |=> electrical_preset_monitor_o == $past(el_sync))
      else $error("monitor not tracking electrical home");
   abs_gate_a: assert property (
      (!absolute_coord_valid_o && !config_reg[`HCM_CFG_ABS_PERM]) |-> !abs_move_ok_o)
      else $error("absolute move allowed without coordinate");
   hs_refuse_a: assert property (
      (electrical_preset_monitor_o || !absolute_coord_valid_o) |-> !hs_home_ok_o)
      else $error("high-speed homing not refused");
   preset_load_a: assert property (
      do_preset |=> pos_load_o && pos_load_value_o == $past(preset_reg[PW-1:0]))
      else $error("preset did not load positions");
   both_homes_a: assert property (
      (set_home && elec_reg && !el_fall) |=> elec_home_o == mech_home_o)
      else $error("electrical and mechanical homes differ");
   homing_invalid_a: assert property (
      homing ##1 homing |-> !absolute_coord_valid_o)
      else $error("coordinate valid during homing");

   preset_seen_c: cover property (do_preset ##2 absolute_coord_valid_o);
   elec_cycle_c:  cover property (el_rise ##[1:50] el_fall);
   home_done_c:   cover property (home_fin && elec_reg);
endmodule : hcm_home_coord
`default_nettype wire

// ===== tb/hcm_host_model.sv
// Host-side model: command position counter and return-to-home sequencer
`default_nettype none
module hcm_host_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        go_home_i,
   input  wire logic        step_en_i,
   input  wire logic [7:0]  home_len_i,
   input  wire logic        pos_load_i,
   input  wire logic [31:0] pos_load_value_i,
   output logic      [31:0] cmd_pos_o,
   output logic             home_start_o,
   output logic             home_done_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Homing sequencer
   logic [7:0] cnt_reg;
   logic       busy_reg;
   wire logic  launch = go_home_i & ~busy_reg;
   wire logic  finish = busy_reg & (cnt_reg == 8'h01);

   // Homing lasts home_len cycles, so the bench can make it prompt or slow
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg      <= 8'h00;
         busy_reg     <= 1'b0;
         home_start_o <= 1'b0;
         home_done_o  <= 1'b0;
         cmd_pos_o    <= 32'h00000000;
      end else begin
         home_start_o <= launch;
         home_done_o  <= finish;
         busy_reg     <= launch | (busy_reg & ~finish);
         cnt_reg      <= launch ? home_len_i : cnt_reg - 8'h01;
         if (pos_load_i) begin
            cmd_pos_o <= pos_load_value_i;
         end else if (step_en_i) begin
            cmd_pos_o <= cmd_pos_o + 32'h00000001;
         end
      end
   end
endmodule : hcm_host_model
`default_nettype wire

// ===== tb/test_home_coordinate_manager.sv
// Self-checking bench for the home coordinate manager
`default_nettype none
`include "hcm_params.svh"
module test_home_coordinate_manager;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Signals and instances
   logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, go_home, step_en;
   logic [7:0]  wb_adr_i, home_len;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, cmd_pos_i, pos_load_value_o, elec_home_o, mech_home_o;
   logic [31:0] rel_pos_o, v, cap, c;
   logic        factory_home_present_i, electrical_preset_in_i, home_start_i, home_done_i;
   logic        res_change_i, factory_origin_stored_o, user_origin_stored_o, pos_load_o;
   logic        electrical_preset_monitor_o, absolute_coord_valid_o, abs_move_ok_o, hs_home_ok_o;
   logic        mech_src_manual_o, gear_src_manual_o, wrap_src_manual_o, limit_disable_o;
   logic        protect_disable_o, motion_param_source_o;
   logic [14:0] gear_ratio_o;
   int          fail_count, cmp_count, seed;

   hcm_home_coord i_hcm_home_coord (
      .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
      .wb_dat_o, .wb_ack_o, .factory_home_present_i, .electrical_preset_in_i, .cmd_pos_i,
      .home_start_i, .home_done_i, .res_change_i, .factory_origin_stored_o,
      .user_origin_stored_o, .electrical_preset_monitor_o, .absolute_coord_valid_o,
      .abs_move_ok_o, .hs_home_ok_o, .pos_load_o, .pos_load_value_o, .elec_home_o,
      .mech_home_o, .rel_pos_o, .mech_src_manual_o, .gear_ratio_o, .gear_src_manual_o,
      .wrap_src_manual_o, .limit_disable_o, .protect_disable_o, .motion_param_source_o
   );

   hcm_host_model i_hcm_host_model (
      .clk_i(clk_i), .rst_i(rst_i), .go_home_i(go_home), .step_en_i(step_en),
      .home_len_i(home_len), .pos_load_i(pos_load_o), .pos_load_value_i(pos_load_value_o),
      .cmd_pos_o(cmd_pos_i), .home_start_o(home_start_i), .home_done_o(home_done_i)
   );

   // 25 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // ==========================================================
   // Expectations, comparison and bus tasks
   function automatic logic [31:0] exp_flags(input int f, u, m, a, p);
      return {26'h0, f[0], u[0], m[0], a[0], a[0] | p[0], a[0] & ~m[0]};
   endfunction : exp_flags

   function automatic logic [31:0] exp_cfg(input logic [31:0] w);
      return {11'h0, w[`HCM_CFG_MECH_MAN], w[`HCM_CFG_WRAP_MAN], w[`HCM_CFG_LIMIT_DIS],
              w[`HCM_CFG_PROT_DIS], w[`HCM_CFG_MOTION_MAN], |w[30:16], w[30:16]};
   endfunction : exp_cfg

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // Classic cycle: hold the request until ack is sampled high, then release
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(name, exp, q);
   endtask : rd

   // Wait for the position load pulse and check the value it carries
   task automatic wait_load(input logic [31:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pos_load_o !== 1'b1 && n < 60);
      if (pos_load_o !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end
      chk("load value", exp, pos_load_value_o);
   endtask : wait_load

   task automatic chk_flags(input int f, u, m, a, p);
      tick(6);
      chk("flags", exp_flags(f, u, m, a, p), {26'h0, factory_origin_stored_o,
          user_origin_stored_o, electrical_preset_monitor_o, absolute_coord_valid_o,
          abs_move_ok_o, hs_home_ok_o});
   endtask : chk_flags

   // ==========================================================
   // Main sequence
   initial begin
      rst_i = 1'b1;
      {wb_we_i, wb_cyc_i, wb_stb_i, factory_home_present_i, electrical_preset_in_i} = '0;
      {res_change_i, go_home, step_en} = '0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      home_len = 8'h0C;
      fail_count = 0;
      cmp_count = 0;
      seed = $urandom(48);
      tick(10);
      rst_i <= 1'b0;
      // Reset state, register reset values, unmapped place
      chk_flags(0, 0, 0, 0, 0);
      rd("config", `HCM_OFS_CONFIG, `HCM_CONFIG_RST);
      rd("preset", `HCM_OFS_PRESET, `HCM_PRESET_RST);
      wr(8'h1C, $urandom);
      rd("unmapped", 8'h1C, 32'h00000000);
      // Factory home follows the encoder and survives the factory command
      factory_home_present_i <= 1'b1;
      chk_flags(1, 0, 0, 1, 0);
      wr(`HCM_OFS_CMD, 32'h1 << `HCM_CMD_FACTORY);
      chk_flags(1, 0, 0, 1, 0);
      factory_home_present_i <= 1'b0;
      chk_flags(0, 0, 0, 0, 0);
      // Preset, resolution change and clear over boundary values
      for (int k = 0; k < 4; k++) begin
         v = (k == 0) ? 32'h0 : (k == 1) ? 32'h80000000 : (k == 2) ? 32'h7FFFFFFF : $urandom;
         wr(`HCM_OFS_PRESET, v);
         wr(`HCM_OFS_CMD, 32'h1 << `HCM_CMD_PRESET);
         wait_load(v);
         chk_flags(0, 1, 0, 1, 0);
         chk("mech home", v, mech_home_o);
         chk("cmd pos", v, cmd_pos_i);
         res_change_i <= 1'b1;
         tick(1);
         res_change_i <= 1'b0;
         chk_flags(0, 1, 0, int'(v == 32'h0), 0);
         wr(`HCM_OFS_CMD, 32'h1 << `HCM_CMD_CLEAR);
         chk_flags(0, 0, 0, 0, 0);
      end
      wr(`HCM_OFS_CONFIG, 32'h1 << `HCM_CFG_ABS_PERM);
      chk_flags(0, 0, 0, 0, 1);
      // Electrical home capture, relative position, preset while held
      step_en <= 1'b1;
      tick(1 + $urandom % 20);
      step_en <= 1'b0;
      tick(2);
      cap = cmd_pos_i;
      electrical_preset_in_i <= 1'b1;
      chk_flags(0, 0, 1, 1, 1);
      chk("elec home", cap, elec_home_o);
      step_en <= 1'b1;
      tick(5);
      step_en <= 1'b0;
      tick(3);
      chk("rel pos", cmd_pos_i - cap, rel_pos_o);
      v = $urandom;
      wr(`HCM_OFS_PRESET, v);
      wr(`HCM_OFS_CMD, 32'h1 << `HCM_CMD_PRESET);
      wait_load(v);
      chk_flags(0, 1, 1, 1, 1);
      chk("elec home", v, elec_home_o);
      chk("mech home", v, mech_home_o);
      rd("elec home reg", `HCM_OFS_ELEC_HOME, v);
      rd("mech home reg", `HCM_OFS_MECH_HOME, v);
      electrical_preset_in_i <= 1'b0;
      chk_flags(0, 1, 0, 1, 1);
      chk("rel pos", cmd_pos_i - v, rel_pos_o);
      rd("rel pos reg", `HCM_OFS_REL_POS, cmd_pos_i - v);
      // Return-to-home with a random length
      home_len <= 8'h0C + 8'($urandom % 12);
      go_home <= 1'b1;
      tick(1);
      go_home <= 1'b0;
      chk_flags(0, 1, 0, 0, 1);
      rd("status", `HCM_OFS_STATUS, (32'h1 << `HCM_ST_HOMING) | (32'h1 << `HCM_ST_USER) |
         (32'h1 << `HCM_ST_ABS_OK));
      wait_load(v);
      chk_flags(0, 1, 0, 1, 1);
      chk("mech home", v, mech_home_o);
      // Factory setting unsets the user home and restores register defaults
      wr(`HCM_OFS_CMD, 32'h1 << `HCM_CMD_FACTORY);
      chk_flags(0, 0, 0, 0, 0);
      rd("config", `HCM_OFS_CONFIG, `HCM_CONFIG_RST);
      rd("preset", `HCM_OFS_PRESET, `HCM_PRESET_RST);
      // Source selectors and gear ratio, corners first
      for (int k = 0; k < 6; k++) begin
         c = $urandom & 32'h7FFF003E;
         if (k < 3) c[30:16] = (k == 0) ? 15'h0000 : (k == 1) ? 15'h0001 : 15'h7FFF;
         if (k < 2) c[5:1] = {5{k[0]}};
         wr(`HCM_OFS_CONFIG, c);
         tick(2);
         chk("config outs", exp_cfg(c), {11'h0, mech_src_manual_o, wrap_src_manual_o,
             limit_disable_o, protect_disable_o, motion_param_source_o, gear_src_manual_o,
             gear_ratio_o});
         rd("config", `HCM_OFS_CONFIG, c);
      end
      report_and_stop();
   end
endmodule : test_home_coordinate_manager
`default_nettype wire
